// *** massive_failure_detect.sv ***
// failure watchdog: resets the host when vertical interrupt acks stop
//
// Behaviour
// [R1] no vertical-interrupt acknowledge within 108 ms while enabled triggers host reset
// [R2] host reset is held asserted for 108 ms, then released
// [R3] io write to 10CH clears the watchdog enable
// [R4] io write to 0CH sets the watchdog enable
// [R5] enable state reads as bit 5 of status register at 02H
// [R6] a disabled watchdog re-enables when host unmasks interrupts
// [R7] software masks interrupts first, then writes 00H to 10CH
// [R8] software must not mask interrupts 100 ms without disabling watchdog
// [R9] boot code: enable clear means power-up, enable set means watchdog reset
// [R10] each acknowledge restarts the timeout interval from zero
// [R11] power-up reset leaves the watchdog enable cleared
`timescale 1ns/1ps
`default_nettype none
`include "wdog_consts.svh"
module massive_failure_detect #(
  parameter int TIMEOUT_CYCLES =
    `WDOG_TIMEOUT_MS * (`WDOG_NS_PER_MS / `WDOG_CLK_PERIOD_NS),
  parameter int HOLD_CYCLES =
    `WDOG_HOLD_MS * (`WDOG_NS_PER_MS / `WDOG_CLK_PERIOD_NS)
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic vint_ack_i,
  input wire logic io_wr_i,
  input wire logic [`WDOG_IO_ADDR_W-1:0] io_addr_i,
  input wire logic unmask_interrupts_instr_i,
  input wire logic [7:0] comm_status_i,
  output logic host_reset_o,
  output logic wdog_enable_o,
  output logic [7:0] comm_status_o
);
  import wdog_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic ack_s;
  logic unmask_s;
  pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .async_i({vint_ack_i, unmask_interrupts_instr_i}),
    .sync_o({ack_s, unmask_s})
  );

  // ****************************************
  // io decode
  // ****************************************
  wire dis_wr = io_wr_i && (io_addr_i == `WDOG_DISABLE_ADDR);
  wire en_wr = io_wr_i && (io_addr_i == `WDOG_ENABLE_ADDR);
  logic ack_d_r;
  logic unmask_d_r;
  wire ack_rise = ack_s && !ack_d_r;
  wire unmask_rise = unmask_s && !unmask_d_r;

  // ****************************************
  // enable flag
  // ****************************************
  logic enable_r;
  logic enable_nxt;
  // enabling wins over a same-cycle disable write
  assign enable_nxt = (en_wr || unmask_rise) ? 1'b1 : // R4 R6
                      dis_wr ? 1'b0 : enable_r; // R3

  // ****************************************
  // timer and state
  // ****************************************
  wdog_state_t state_r;
  wdog_state_t state_nxt;
  logic [`WDOG_CNT_W-1:0] cnt_r;
  logic [`WDOG_CNT_W-1:0] cnt_nxt;
  wire [`WDOG_CNT_W-1:0] to_last = `WDOG_CNT_W'(TIMEOUT_CYCLES - 1);
  wire [`WDOG_CNT_W-1:0] hold_last = `WDOG_CNT_W'(HOLD_CYCLES - 1);

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_IDLE:
      begin
        cnt_nxt = '0;
        if (enable_r)
          state_nxt = ST_WATCH;
      end
      ST_WATCH:
      begin
        if (!enable_r)
        begin
          state_nxt = ST_IDLE;
          cnt_nxt = '0;
        end
        else if (ack_rise)
          cnt_nxt = '0; // R10
        else if (cnt_r == to_last)
        begin
          state_nxt = ST_HOLD; // R1
          cnt_nxt = '0;
        end
        else
          cnt_nxt = cnt_r + `WDOG_CNT_W'(1);
      end
      ST_HOLD:
      begin
        if (cnt_r == hold_last)
        begin
          state_nxt = ST_WATCH; // R2
          cnt_nxt = '0;
        end
        else
          cnt_nxt = cnt_r + `WDOG_CNT_W'(1);
      end
      default:
      begin
        state_nxt = ST_IDLE;
        cnt_nxt = '0;
      end
    endcase
  end

  wire [7:0] status_nxt = {comm_status_i[7:`WDOG_STATUS_EN_BIT+1], enable_nxt,
                           comm_status_i[`WDOG_STATUS_EN_BIT-1:0]};

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      enable_r <= 1'b0; // R11
      state_r <= ST_IDLE;
      cnt_r <= '0;
      ack_d_r <= 1'b0;
      unmask_d_r <= 1'b0;
      host_reset_o <= 1'b0;
      wdog_enable_o <= 1'b0;
      comm_status_o <= '0;
    end
    else
    begin
      enable_r <= enable_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ack_d_r <= ack_s;
      unmask_d_r <= unmask_s;
      host_reset_o <= (state_nxt == ST_HOLD); // R2
      wdog_enable_o <= enable_nxt; // R5
      comm_status_o <= status_nxt; // R5
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_dis_clears;
    @(posedge core_clk_i) disable iff (!rstn_i)
    (dis_wr && !en_wr && !unmask_rise) |=> !enable_r;
  endproperty
  a_dis_clears: assert property (p_dis_clears) else $error("disable write ignored"); // R3

  property p_en_sets;
    @(posedge core_clk_i) disable iff (!rstn_i)
    en_wr |=> enable_r;
  endproperty
  a_en_sets: assert property (p_en_sets) else $error("enable write ignored"); // R4

  property p_status_bit;
    @(posedge core_clk_i) disable iff (!rstn_i)
    1'b1 |=> (comm_status_o[`WDOG_STATUS_EN_BIT] == enable_r) &&
      (comm_status_o[7:`WDOG_STATUS_EN_BIT+1] ==
       $past(comm_status_i[7:`WDOG_STATUS_EN_BIT+1])) &&
      (comm_status_o[`WDOG_STATUS_EN_BIT-1:0] ==
       $past(comm_status_i[`WDOG_STATUS_EN_BIT-1:0]));
  endproperty
  a_status_bit: assert property (p_status_bit) else $error("status bit wrong"); // R5

  property p_unmask_reenables;
    @(posedge core_clk_i) disable iff (!rstn_i)
    $rose(unmask_s) |=> enable_r;
  endproperty
  a_unmask_reenables: assert property (p_unmask_reenables) else $error("no re-enable"); // R6

  property p_timeout_fires;
    @(posedge core_clk_i) disable iff (!rstn_i)
    (state_r == ST_WATCH && enable_r && !ack_rise && cnt_r == to_last)
      |=> state_r == ST_HOLD ##0 host_reset_o;
  endproperty
  a_timeout_fires: assert property (p_timeout_fires) else $error("timeout missed"); // R1

  property p_ack_restarts;
    @(posedge core_clk_i) disable iff (!rstn_i)
    (state_r == ST_WATCH && enable_r && ack_rise) |=> cnt_r == '0;
  endproperty
  a_ack_restarts: assert property (p_ack_restarts) else $error("ack not restarting"); // R10

  property p_hold_releases;
    @(posedge core_clk_i) disable iff (!rstn_i)
    (state_r == ST_HOLD && cnt_r == hold_last) |=> !host_reset_o;
  endproperty
  a_hold_releases: assert property (p_hold_releases) else $error("reset not released"); // R2

  property p_reset_only_hold;
    @(posedge core_clk_i) disable iff (!rstn_i)
    host_reset_o == (state_r == ST_HOLD);
  endproperty
  a_reset_only_hold: assert property (p_reset_only_hold) else $error("stray reset"); // R1
endmodule
`default_nettype wire

// *** wdog_consts.svh ***
// constants for the failure watchdog
`ifndef WDOG_CONSTS_SVH
`define WDOG_CONSTS_SVH
// io addresses and status bit; the watchdog decodes only the disable and enable addresses
`define WDOG_IO_ADDR_W 12
`define WDOG_DISABLE_ADDR 12'h10C
`define WDOG_ENABLE_ADDR 12'h00C
`define WDOG_STATUS_ADDR 12'h002
`define WDOG_STATUS_EN_BIT 5
// timing: 108 ms at 4 ns per cycle
`define WDOG_TIMEOUT_MS 108
`define WDOG_HOLD_MS 108
`define WDOG_CLK_PERIOD_NS 4
`define WDOG_NS_PER_MS 1000000
`define WDOG_CNT_W 32
`endif

// *** wdog_pkg.sv ***
// types for the failure watchdog
`default_nettype none
package wdog_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WATCH,
    ST_HOLD
  } wdog_state_t;
endpackage
`default_nettype wire

// *** pin_sync.sv ***
// two flip-flop synchroniser for a bundle of pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta_r <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

// *** host_model.sv ***
// host side: interrupt acknowledge pulses and mask level
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic irq_on_i,
  output logic vint_ack_o,
  output logic unmask_o
);
  logic [2:0] cnt_r;
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cnt_r <= 3'h0;
    else
      cnt_r <= cnt_r + 3'h1;
  end
  // acks come only while interrupts are unmasked
  assign vint_ack_o = irq_on_i & cnt_r[2];
  assign unmask_o = irq_on_i;
endmodule
`default_nettype wire

// *** massive_failure_detect_tb.sv ***
// testbench for the failure watchdog
`timescale 1ns/1ps
`default_nettype none
module massive_failure_detect_tb;
  // ****
  // stimulus and checks
  // ****
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic io_wr_i = 1'b0;
  logic [11:0] io_addr_i = 12'h000;
  logic irq_on = 1'b0;
  logic [7:0] cs_i = 8'hFF;
  logic ack, unm, rst_o, en_o;
  logic [7:0] cs_o;
  int n_errors = 0;
  int total_checks = 0;
  int n;
  localparam int TO_CYC = 20;
  localparam int HOLD_CYC = 10;
  logic [12:0] rows [6] = '{13'h0019, 13'h0218, 13'h0004, 13'h0019, 13'h01FF, 13'h0218};
  always #2 core_clk_i = ~core_clk_i;
  host_model hm (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .irq_on_i(irq_on), .vint_ack_o(ack),
    .unmask_o(unm));
  massive_failure_detect #(.TIMEOUT_CYCLES(TO_CYC), .HOLD_CYCLES(HOLD_CYC)) dut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .vint_ack_i(ack), .io_wr_i(io_wr_i),
    .io_addr_i(io_addr_i), .unmask_interrupts_instr_i(unm), .comm_status_i(cs_i),
    .host_reset_o(rst_o), .wdog_enable_o(en_o), .comm_status_o(cs_o));
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic io_write(input logic [11:0] a);
    @(posedge core_clk_i);
    io_wr_i <= 1'b1;
    io_addr_i <= a;
    @(posedge core_clk_i);
    io_wr_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
  endtask
  task automatic idle(input int c);
    n = 0;
    repeat (c)
    begin
      @(posedge core_clk_i);
      #1;
      if (rst_o !== 1'b0) n++;
    end
  endtask
  task automatic complete_run;
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #12000;
    n_errors++;
    complete_run;
  end
  initial
  begin
    repeat (8) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    #1;
    check("enable", en_o, 1'b0);
    check("status", cs_o, 8'h00);
    @(posedge core_clk_i);
    irq_on <= 1'b1;
    idle(6);
    check("unmask", en_o, 1'b1);
    foreach (rows[i])
    begin
      io_write(rows[i][12:1]);
      check("enable", en_o, rows[i][0]);
      check("status", cs_o, {2'b11, rows[i][0], 5'h1F});
    end
    // mask first, then disable
    @(posedge core_clk_i);
    irq_on <= 1'b0;
    io_write(12'h10C);
    check("masked enable", en_o, 1'b0);
    idle(40);
    check("idle reset", 8'(n), 8'h00);
    io_write(12'h00C);
    n = 0;
    while (rst_o !== 1'b1 && n < 60)
    begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    check("timeout", 8'(n), 8'(TO_CYC));
    n = 0;
    while (rst_o === 1'b1 && n < 40)
    begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    check("hold", 8'(n), 8'(HOLD_CYC));
    check("boot enable", en_o, 1'b1);
    @(posedge core_clk_i);
    irq_on <= 1'b1;
    idle(80);
    check("serviced", 8'(n), 8'h00);
    @(posedge core_clk_i);
    rstn_i <= 1'b0;
    irq_on <= 1'b0;
    #1;
    check("reset enable", en_o, 1'b0);
    check("reset out", rst_o, 1'b0);
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    idle(8);
    check("power-up enable", en_o, 1'b0);
    check("restart reset", 8'(n), 8'h00);
    complete_run;
  end
endmodule
`default_nettype wire
